/* File: hw/gdm_cond_eval.sv */
// Condition evaluator for the conditional move.
`timescale 1ns/1ps
`include "gdm_params.svh"
module gdm_cond_eval (
  // Inputs.
  input  wire logic [3:0]  cond,
  input  wire logic [63:0] flags,
  // Result.
  output logic             holds
);
  logic carry_flag;    // Carry.
  logic parity_flag;   // Parity.
  logic zero_flag;     // Zero.
  logic sign_flag;     // Sign.
  logic overflow_flag; // Overflow.
  logic base;          // Condition before the low-bit inversion.
  assign carry_flag    = flags[`GDM_CARRY_BIT];
  assign parity_flag   = flags[`GDM_PARITY_BIT];
  assign zero_flag     = flags[`GDM_ZERO_BIT];
  assign sign_flag     = flags[`GDM_SIGN_BIT];
  assign overflow_flag = flags[`GDM_OVERFLOW_BIT];
  // Each pair of alternate names maps onto one code; odd codes invert.
  always_comb begin
    case (cond[3:1])
      3'h0: base = overflow_flag;
      3'h1: base = carry_flag;
      3'h2: base = zero_flag;
      3'h3: base = carry_flag | zero_flag;
      3'h4: base = sign_flag;
      3'h5: base = parity_flag;
      3'h6: base = sign_flag ^ overflow_flag;
      3'h7: base = (sign_flag ^ overflow_flag) |
                   zero_flag;
      default: base = 1'b0;
    endcase
  end
  assign holds = base ^ cond[0];
endmodule

/* File: hw/gdm_unit.sv */
// Execution unit for plain and conditional moves in 64-bit mode.
`timescale 1ns/1ps
`include "gdm_params.svh"
module gdm_unit (
  // Clock and reset.
  input  wire logic                 clk,
  input  wire logic                 sys_rst,
  // Mode.
  input  wire logic                 long_mode,
  // Instruction issue.
  input  wire logic                 issue_valid,
  input  wire gdm_pkg::gdm_instr_t  issue,
  // Flags produced by the preceding instruction.
  input  wire logic                 flags_wr,
  input  wire logic [63:0]          flags_in,
  // Memory and special register source data.
  input  wire logic [63:0]          mem_rdata,
  input  wire logic [63:0]          side_rdata,
  // Results.
  output gdm_pkg::gdm_result_t      result,
  output logic [63:0]               wide_flags_register,
  output logic [63:0]               wide_instruction_pointer,
  output logic [31:0]               feature_word,
  // Register file read port for debug.
  input  wire logic [3:0]           dbg_sel,
  output logic [63:0]               dbg_data
);
  // =====================================================================
  // State.
  logic [63:0] gpr_r [16];           // Sixteen general registers.
  logic [63:0] flags_r;              // Wide flags register.
  logic [63:0] ip_r;                 // Wide instruction pointer.
  gdm_pkg::gdm_result_t res_r;       // Registered result.
  // Decode signals.
  logic              cond_ok;        // Condition holds.
  logic              path_ok;        // Move path legal.
  logic              reg_ok;         // Register numbers reachable.
  gdm_pkg::gdm_width_t width;        // Effective width.
  logic [63:0]       src_val;        // Raw source.
  logic [63:0]       masked;         // Source cut to width.
  logic [63:0]       flags_now;      // Flags visible to this instruction.
  logic [63:0]       wr_data;        // Value written back.
  logic              dst_gpr;        // Destination is the register file.

  // Forward flags written in the same cycle so the test is never stale.
  assign flags_now = flags_wr ? flags_in : flags_r;

  gdm_cond_eval u_cond (
    .cond  (issue.cond),
    .flags (flags_now),
    .holds (cond_ok)
  );

  // =====================================================================
  // Width selection from default size, prefixes and byte opcodes.
  always_comb begin
    if (issue.byte_op) begin
      width = gdm_pkg::GDM_W8;
    end else if (long_mode && (issue.wide_prefix || issue.default_64)) begin
      width = gdm_pkg::GDM_W64;
    end else if (issue.size_override) begin
      width = gdm_pkg::GDM_W16;
    end else begin
      width = gdm_pkg::GDM_W32;
    end
    if (issue.op == gdm_pkg::GDM_OP_CMOVE && width == gdm_pkg::GDM_W8) begin
      width = gdm_pkg::GDM_W32;
    end
  end

  // Upper registers need the extension prefix and 64-bit mode.
  always_comb begin
    reg_ok = 1'b1;
    if ((issue.src == gdm_pkg::GDM_LOC_GPR && issue.src_reg[3]) ||
        (dst_gpr && issue.dst_reg[3])) begin
      reg_ok = long_mode && issue.ext_prefix;
    end
  end

  // Legal move paths.
  always_comb begin
    path_ok = 1'b0;
    case (issue.op)
      gdm_pkg::GDM_OP_MOVE: begin
        case (issue.dst)
          gdm_pkg::GDM_LOC_GPR: path_ok = 1'b1;
          gdm_pkg::GDM_LOC_MEM:
            path_ok = issue.src == gdm_pkg::GDM_LOC_GPR ||
                      issue.src == gdm_pkg::GDM_LOC_SEG ||
                      issue.src == gdm_pkg::GDM_LOC_IMM;
          gdm_pkg::GDM_LOC_SEG:
            path_ok = issue.src == gdm_pkg::GDM_LOC_GPR ||
                      issue.src == gdm_pkg::GDM_LOC_MEM;
          gdm_pkg::GDM_LOC_CR, gdm_pkg::GDM_LOC_DR:
            path_ok = issue.src == gdm_pkg::GDM_LOC_GPR;
          default: path_ok = 1'b0;
        endcase
        if (issue.dst == gdm_pkg::GDM_LOC_GPR &&
            issue.src == gdm_pkg::GDM_LOC_IMM) begin
          path_ok = 1'b1;
        end
      end
      gdm_pkg::GDM_OP_CMOVE:
        path_ok = issue.dst == gdm_pkg::GDM_LOC_GPR &&
                  (issue.src == gdm_pkg::GDM_LOC_GPR ||
                   issue.src == gdm_pkg::GDM_LOC_MEM);
      gdm_pkg::GDM_OP_FEAT: path_ok = 1'b1;
      default: path_ok = 1'b0;
    endcase
  end

  // Source value selection.
  always_comb begin
    case (issue.src)
      gdm_pkg::GDM_LOC_GPR: src_val = gpr_r[issue.src_reg];
      gdm_pkg::GDM_LOC_MEM: src_val = mem_rdata;
      gdm_pkg::GDM_LOC_IMM: src_val = issue.imm;
      default:              src_val = side_rdata;
    endcase
  end

  // Cut to the effective width.
  always_comb begin
    case (width)
      gdm_pkg::GDM_W8:  masked = {56'h0, src_val[7:0]};
      gdm_pkg::GDM_W16: masked = {48'h0, src_val[15:0]};
      gdm_pkg::GDM_W32: masked = {32'h0, src_val[31:0]};
      default:          masked = src_val;
    endcase
  end

  // Value written back; the feature query returns its word zero-extended.
  assign wr_data = issue.op == gdm_pkg::GDM_OP_FEAT ?
                   {32'h0, feature_word} : masked;
  // The feature query always lands in a general register.
  assign dst_gpr = issue.dst == gdm_pkg::GDM_LOC_GPR ||
                   issue.op == gdm_pkg::GDM_OP_FEAT;

  // =====================================================================
  // Result register; a failed condition still retires but writes nothing.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      res_r <= '0;
    end else begin
      res_r.valid   <= issue_valid;
      res_r.fault   <= issue_valid && !(path_ok && reg_ok);
      res_r.writes  <= issue_valid && path_ok && reg_ok &&
                       (issue.op != gdm_pkg::GDM_OP_CMOVE || cond_ok) &&
                       issue.op != gdm_pkg::GDM_OP_NONE;
      res_r.dst     <= issue.op == gdm_pkg::GDM_OP_FEAT ?
                       gdm_pkg::GDM_LOC_GPR : issue.dst;
      res_r.dst_reg <= issue.dst_reg;
      res_r.width   <= width;
      res_r.data    <= wr_data;
    end
  end
  assign result = res_r;

  // General register file with sixteen 64-bit entries.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < 16; i++) gpr_r[i] <= 64'h0;
    end else if (issue_valid && path_ok && reg_ok && dst_gpr &&
                 (issue.op == gdm_pkg::GDM_OP_MOVE ||
                  issue.op == gdm_pkg::GDM_OP_FEAT ||
                  (issue.op == gdm_pkg::GDM_OP_CMOVE && cond_ok))) begin
      gpr_r[issue.dst_reg] <= wr_data;
    end
  end

  // Wide flags register.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      flags_r <= `GDM_FLAGS_RST;
    end else if (flags_wr) begin
      flags_r <= long_mode ? flags_in : {32'h0, flags_in[31:0]};
    end
  end

  // Wide instruction pointer advances on each retired instruction.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ip_r <= `GDM_IP_RST;
    end else if (issue_valid) begin
      if (long_mode) begin
        ip_r <= ip_r + {60'h0, issue.length};
      end else begin
        ip_r <= {32'h0, ip_r[31:0] + {28'h0, issue.length}};
      end
    end
  end
  assign wide_flags_register      = flags_r;
  assign wide_instruction_pointer = ip_r;

  // Feature word reports conditional move support.
  assign feature_word = 32'h1 << `GDM_FEAT_CMOV_BIT;
  assign dbg_data     = gpr_r[dbg_sel];

  // =====================================================================
  // Assertions.
  cmov_skip_a: assert property (@(posedge clk) disable iff (sys_rst)
    issue_valid && issue.op == gdm_pkg::GDM_OP_CMOVE && !cond_ok
    |=> !res_r.writes) else $error("conditional move wrote on false");
  cmov_take_a: assert property (@(posedge clk) disable iff (sys_rst)
    issue_valid && issue.op == gdm_pkg::GDM_OP_CMOVE && cond_ok &&
    path_ok && reg_ok |=> res_r.writes) else $error("cmove not taken");
  mem_mem_a: assert property (@(posedge clk) disable iff (sys_rst)
    issue_valid && issue.src == gdm_pkg::GDM_LOC_MEM &&
    issue.dst == gdm_pkg::GDM_LOC_MEM |=> res_r.fault && !res_r.writes)
    else $error("memory to memory move accepted");
  seg_seg_a: assert property (@(posedge clk) disable iff (sys_rst)
    issue_valid && issue.op == gdm_pkg::GDM_OP_MOVE &&
    issue.src == gdm_pkg::GDM_LOC_SEG && issue.dst == gdm_pkg::GDM_LOC_SEG
    |=> res_r.fault) else $error("segment to segment move accepted");
  ext_reg_a: assert property (@(posedge clk) disable iff (sys_rst)
    issue_valid && issue.dst == gdm_pkg::GDM_LOC_GPR && issue.dst_reg[3] &&
    !issue.ext_prefix |=> !res_r.writes) else $error("upper reg no prefix");
  wide_op_a: assert property (@(posedge clk) disable iff (sys_rst)
    issue_valid && long_mode && issue.wide_prefix && !issue.byte_op
    |=> res_r.width == gdm_pkg::GDM_W64) else $error("64-bit width missed");
  cmov_width_a: assert property (@(posedge clk) disable iff (sys_rst)
    issue_valid && issue.op == gdm_pkg::GDM_OP_CMOVE && !long_mode |=>
    res_r.width inside {gdm_pkg::GDM_W16, gdm_pkg::GDM_W32})
    else $error("cmove width");
  ip_step_a: assert property (@(posedge clk) disable iff (sys_rst)
    issue_valid && long_mode |=>
    ip_r == $past(ip_r) + {60'h0, $past(issue.length)})
    else $error("instruction pointer step wrong");
  feat_a: assert property (@(posedge clk) disable iff (sys_rst)
    feature_word[`GDM_FEAT_CMOV_BIT]) else $error("feature bit clear");
  cmov_taken_c: cover property (@(posedge clk)
    issue_valid && issue.op == gdm_pkg::GDM_OP_CMOVE && cond_ok);
  cmov_skip_c: cover property (@(posedge clk)
    issue_valid && issue.op == gdm_pkg::GDM_OP_CMOVE && !cond_ok);
  fwd_flags_c: cover property (@(posedge clk)
    issue_valid && flags_wr && issue.op == gdm_pkg::GDM_OP_CMOVE);
endmodule

/* File: pkg/gdm_params.svh */
// Constants for the general-purpose data-movement unit.
// What this block does
// - Sixteen general registers in 64-bit mode.
// - Upper eight registers need the extension prefix.
// - All sixteen usable as 64-bit operands.
// - Flags register widened to 64 bits.
// - Instruction pointer widened to 64 bits.
// - Byte, word, dword, qword widths by size.
// - Plain move supports listed source/destination paths.
// - No memory-to-memory or segment-to-segment move.
// - Conditional move writes only when condition holds.
// - Conditional move: 16/32-bit into general register, 64-bit in 64-bit mode.
// - Alternate mnemonics share one condition encoding.
// - Feature query reports conditional move support.
// - Unsigned conditions from carry and zero.
// - Signed conditions from sign, overflow, zero.
// - Single-flag conditions test one flag.
`ifndef GDM_PARAMS_SVH
`define GDM_PARAMS_SVH
// =====================================================================
// Flag bit positions inside the wide flags register.
`define GDM_CARRY_BIT    6'd0
`define GDM_PARITY_BIT   6'd2
`define GDM_ZERO_BIT     6'd6
`define GDM_SIGN_BIT     6'd7
`define GDM_OVERFLOW_BIT 6'd11
// Reset values.
`define GDM_FLAGS_RST    64'h0000_0000_0000_0002
`define GDM_IP_RST       64'h0000_0000_0000_0000
// Feature bit index of conditional move in the feature word.
`define GDM_FEAT_CMOV_BIT 5'd15
// Cycles from issue until an instruction retires.
`define GDM_RETIRE_CYCLES 2'd1
`endif

/* File: pkg/gdm_pkg.sv */
// Types shared by the data-movement unit.
package gdm_pkg;
  // =====================================================================
  // Operand locations.
  typedef enum logic [2:0] {
    GDM_LOC_GPR = 3'h0,
    GDM_LOC_MEM = 3'h1,
    GDM_LOC_SEG = 3'h2,
    GDM_LOC_CR  = 3'h3,
    GDM_LOC_DR  = 3'h4,
    GDM_LOC_IMM = 3'h5
  } gdm_loc_t;
  // Operand widths.
  typedef enum logic [1:0] {
    GDM_W8  = 2'h0,
    GDM_W16 = 2'h1,
    GDM_W32 = 2'h2,
    GDM_W64 = 2'h3
  } gdm_width_t;
  // Operation kinds.
  typedef enum logic [1:0] {
    GDM_OP_NONE  = 2'h0,
    GDM_OP_MOVE  = 2'h1,
    GDM_OP_CMOVE = 2'h2,
    GDM_OP_FEAT  = 2'h3
  } gdm_op_t;
  // Decoded instruction presented to the unit.
  typedef struct packed {
    gdm_op_t    op;
    gdm_loc_t   src;
    gdm_loc_t   dst;
    logic [3:0] src_reg;
    logic [3:0] dst_reg;
    logic [3:0] cond;
    logic       ext_prefix;
    logic       wide_prefix;
    logic       size_override;
    logic       byte_op;
    logic       default_64;
    logic [3:0] length;
    logic [63:0] imm;
  } gdm_instr_t;
  // Result handed to the register files and memory.
  typedef struct packed {
    logic        valid;
    logic        fault;
    logic        writes;
    gdm_loc_t    dst;
    logic [3:0]  dst_reg;
    gdm_width_t  width;
    logic [63:0] data;
  } gdm_result_t;
endpackage

/* File: verification/gdm_mem_model.sv */
// Partner model: memory and special register read data for the unit.
`timescale 1ns/1ps
module gdm_mem_model (
  // Read strobe from the bench, high in the issue cycle.
  input  wire logic        load,
  // Words that memory and the special registers hold.
  input  wire logic [63:0] mem_val,
  input  wire logic [63:0] side_val,
  // Read data towards the unit.
  output logic [63:0]      mem_rdata,
  output logic [63:0]      side_rdata
);
  // =====================================================================
  // Read path.
  // Outside a read the buses show inverted data, so a stale word is caught.
  always_comb begin
    mem_rdata  = load ? mem_val : ~mem_val;
    side_rdata = load ? side_val : ~side_val;
  end
endmodule

/* File: verification/test_gdm_unit.sv */
// Self-checking testbench of the data-movement unit.
`timescale 1ns/1ps
module test_gdm_unit;
  // =====================================================================
  // Stimulus and observed signals.
  logic clk = 1'b0, sys_rst = 1'b1, long_mode = 1'b1, issue_valid = 1'b0;
  logic flags_wr = 1'b0, load = 1'b0;
  logic [3:0] dbg_sel = 4'h0;
  logic [63:0] flags_in = '0, mem_val = '0, side_val = '0, ip_m = '0;
  logic [63:0] fl_m = 64'h2, mem_rdata, side_rdata, wfl, wip, dbg_data;
  logic [63:0] gpr_m [16];
  logic [31:0] feat, seed = 32'h70C6995B;
  gdm_pkg::gdm_instr_t issue = '0;
  gdm_pkg::gdm_result_t result;
  int n_errors = 0, check_count = 0, cyc = 0;
  // Thirteen legal source/destination pairs, then the forbidden ones.
  logic [5:0] paths [18] = '{6'h08, 6'h0A, 6'h01, 6'h11, 6'h00, 6'h02,
    6'h10, 6'h03, 6'h18, 6'h04, 6'h20, 6'h28, 6'h29, 6'h09, 6'h12,
    6'h19, 6'h21, 6'h2A};
  // =====================================================================
  // Clock, timeout and instances.
  always #25 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      report_and_stop();
    end
  end
  gdm_mem_model MEM (.load(load), .mem_val(mem_val), .side_val(side_val),
    .mem_rdata(mem_rdata), .side_rdata(side_rdata));
  gdm_unit DUT (.clk(clk), .sys_rst(sys_rst), .long_mode(long_mode),
    .issue_valid(issue_valid), .issue(issue), .flags_wr(flags_wr),
    .flags_in(flags_in), .mem_rdata(mem_rdata), .side_rdata(side_rdata),
    .result(result), .wide_flags_register(wfl),
    .wide_instruction_pointer(wip), .feature_word(feat),
    .dbg_sel(dbg_sel), .dbg_data(dbg_data));
  // =====================================================================
  // Helpers: random source, condition model, width mask, compare.
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic holds(input logic [3:0] c, input logic [63:0] f);
    logic r;
    case (c[3:1])
      3'h0: r = f[11];
      3'h1: r = f[0];
      3'h2: r = f[6];
      3'h3: r = f[0] | f[6];
      3'h4: r = f[7];
      3'h5: r = f[2];
      3'h6: r = f[7] ^ f[11];
      default: r = (f[7] ^ f[11]) | f[6];
    endcase
    return r ^ c[0];
  endfunction
  function automatic logic [63:0] mask(input gdm_pkg::gdm_width_t w);
    return (w == gdm_pkg::GDM_W8) ? 64'hFF : (w == gdm_pkg::GDM_W16) ?
      64'hFFFF : (w == gdm_pkg::GDM_W32) ? 64'hFFFF_FFFF : '1;
  endfunction
  task automatic chk(input string nm, input logic [63:0] e,
                     input logic [63:0] g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s exp=%h got=%h", nm, e, g);
    end
  endtask
  function automatic gdm_pkg::gdm_instr_t mk(input gdm_pkg::gdm_op_t o,
      input logic [5:0] p, input logic [3:0] c, input logic [3:0] len);
    gdm_pkg::gdm_instr_t i;
    logic [31:0] r;
    r = rnd();
    i = '0;
    i.op = o;
    i.src = gdm_pkg::gdm_loc_t'(p[5:3]);
    i.dst = gdm_pkg::gdm_loc_t'(p[2:0]);
    i.src_reg = r[3:0];
    i.dst_reg = r[7:4];
    i.cond = c;
    i.ext_prefix = 1'b1;
    i.wide_prefix = 1'b1;
    i.length = len;
    i.imm = {rnd(), rnd()};
    return i;
  endfunction
  // =====================================================================
  // One instruction: drive, let it retire, compare with the model.
  task automatic run(input gdm_pkg::gdm_instr_t i, input logic fw,
                     input logic [63:0] fv);
    logic [63:0] sv, fn;
    logic bad, wr, sp;
    gdm_pkg::gdm_width_t w;
    mem_val = {rnd(), rnd()};
    side_val = {48'h0, 16'(rnd())};
    fn = fw ? fv : fl_m;
    bad = i.op != gdm_pkg::GDM_OP_FEAT;
    for (int j = 0; j < 13; j++)
      if ({i.src, i.dst} == paths[j] && (i.op == gdm_pkg::GDM_OP_MOVE ||
          paths[j][5:4] == 2'h0 && paths[j][2:0] == 3'h0))
        bad = 1'b0;
    bad = bad || ((!i.ext_prefix || !long_mode) &&
      ((i.dst == gdm_pkg::GDM_LOC_GPR && i.dst_reg[3]) ||
       (i.src == gdm_pkg::GDM_LOC_GPR && i.src_reg[3])));
    sp = i.src > gdm_pkg::GDM_LOC_MEM && i.src < gdm_pkg::GDM_LOC_IMM ||
      i.dst > gdm_pkg::GDM_LOC_MEM;
    case (i.src)
      gdm_pkg::GDM_LOC_GPR: sv = gpr_m[i.src_reg];
      gdm_pkg::GDM_LOC_MEM: sv = mem_val;
      gdm_pkg::GDM_LOC_IMM: sv = i.imm;
      default: sv = side_val;
    endcase
    if (i.op == gdm_pkg::GDM_OP_FEAT)
      sv = 64'h8000;
    w = i.byte_op ? gdm_pkg::GDM_W8 :
      (long_mode && (i.wide_prefix | i.default_64)) ?
      gdm_pkg::GDM_W64 : i.size_override ? gdm_pkg::GDM_W16 :
      gdm_pkg::GDM_W32;
    wr = !bad && (i.op != gdm_pkg::GDM_OP_CMOVE || holds(i.cond, fn));
    @(posedge clk);
    #1;
    issue = i;
    issue_valid = 1'b1;
    flags_wr = fw;
    flags_in = fv;
    load = 1'b1;
    dbg_sel = i.dst_reg;
    @(posedge clk);
    #1;
    issue_valid = 1'b0;
    flags_wr = 1'b0;
    load = 1'b0;
    if (fw)
      fl_m = long_mode ? fv : {32'h0, fv[31:0]};
    ip_m = long_mode ? ip_m + 64'(i.length) :
      {32'h0, ip_m[31:0] + 32'(i.length)};
    chk("valid", 64'h1, 64'(result.valid));
    chk("fault", 64'(bad), 64'(result.fault));
    chk("writes", 64'(wr), 64'(result.writes));
    if (wr && i.dst != gdm_pkg::GDM_LOC_SEG)
      chk("data", sv & mask(w), result.data);
    if (!bad && !sp)
      chk("width", 64'(w), 64'(result.width));
    if (wr && i.dst == gdm_pkg::GDM_LOC_GPR)
      gpr_m[i.dst_reg] = sv & mask(w);
    if (i.dst == gdm_pkg::GDM_LOC_GPR)
      chk("gpr", gpr_m[i.dst_reg], dbg_data);
    chk("flags", fl_m, wfl);
    chk("ip", ip_m, wip);
  endtask
  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // =====================================================================
  // Main sequence.
  initial begin
    gdm_pkg::gdm_instr_t i;
    for (int r = 0; r < 16; r++) gpr_m[r] = '0;
    repeat (4) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    chk("flags_rst", 64'h2, wfl);
    chk("ip_rst", 64'h0, wip);
    chk("feature", 64'h1, 64'(feat[15]));
    // Every register loaded with a 64-bit immediate.
    for (int r = 0; r < 16; r++) begin
      i = mk(gdm_pkg::GDM_OP_MOVE, 6'h28, 4'h0, 4'(r + 1));
      i.dst_reg = 4'(r);
      i.ext_prefix = i.dst_reg[3];
      run(i, 1'b0, '0);
    end
    // Operand widths on immediate-to-memory moves, in and out of 64-bit mode.
    for (int k = 0; k < 8; k++) begin
      long_mode = k[2];
      i = mk(gdm_pkg::GDM_OP_MOVE, 6'h29, 4'h0, 4'h3);
      i.byte_op = (k[1:0] == 2'h0);
      i.size_override = (k[1:0] == 2'h1);
      i.wide_prefix = (k[1:0] == 2'h3);
      run(i, 1'b0, '0);
    end
    // Conditional moves, flags forwarded or taken from the register.
    for (int k = 0; k < 64; k++) begin
      long_mode = k[3];
      i = mk(gdm_pkg::GDM_OP_CMOVE, k[5] ? 6'h08 : 6'h00, 4'(k), 4'h2);
      i.wide_prefix = 1'b0;
      i.size_override = k[2];
      run(i, k[4], {rnd(), rnd()} | 64'h2);
    end
    // Legal move paths, then forbidden ones and missing prefixes.
    for (int k = 0; k < 18; k++) begin
      run(mk(gdm_pkg::GDM_OP_MOVE, paths[k], 4'h0, 4'h1), 1'b0, '0);
    end
    i = mk(gdm_pkg::GDM_OP_MOVE, 6'h28, 4'h0, 4'h1);
    i.ext_prefix = 1'b0;
    i.dst_reg = 4'hC;
    run(i, 1'b0, '0);
    i = mk(gdm_pkg::GDM_OP_MOVE, 6'h00, 4'h0, 4'h1);
    i.ext_prefix = 1'b0;
    i.src_reg = 4'hA;
    i.dst_reg = 4'h1;
    run(i, 1'b0, '0);
    // Feature query lands its word in a general register.
    run(mk(gdm_pkg::GDM_OP_FEAT, 6'h00, 4'h0, 4'h2), 1'b0, '0);
    report_and_stop();
  end
endmodule
